// ### shared/pwr_pkg.sv
// Shared constants and types for the power mode and external wake controller
package pwr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SENSE     = 8'h00;
  localparam logic [7:0] OFS_PINSEL    = 8'h04;
  localparam logic [7:0] OFS_CLKCTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;

  localparam logic [7:0] SENSE_RESET   = 8'h00;
  localparam logic [7:0] PINSEL_RESET  = 8'h0c;
  localparam logic [7:0] CLKCTRL_RESET = 8'h00;

  // Field positions: sensitivity and pin select share the same layout
  localparam int LINE3_LSB = 6;
  localparam int LINE2_LSB = 4;
  localparam int LINE1_LSB = 2;
  localparam int LINE0_LSB = 0;

  // Clock control register bits
  localparam int CTL_SLOW_BIT        = 0;
  localparam int CTL_AUTO_WAKE_BIT   = 1;
  localparam int CTL_ACTIVE_HALT_BIT = 2;
  localparam int CTL_LONG_STAB_BIT   = 3;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_MASK_BIT = 3;
  localparam int ST_REQ_LSB  = 4;
  localparam int ST_SLOW_BIT = 8;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE     = 2'h1;
  localparam logic [1:0] SENSE_FALL     = 2'h2;
  localparam logic [1:0] SENSE_BOTH     = 2'h3;

  localparam logic [1:0] LINE2_NOWAKE_SEL = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_HALT,
    MODE_STABILISE,
    MODE_PLL_START
  } mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 100;
  localparam int OSC_TO_MASTER_DIV  = 2;
  localparam int SLOW_OSC_DIV       = 32;
  localparam int SLOW_TICK_CYCLES   = SLOW_OSC_DIV / OSC_TO_MASTER_DIV;
  localparam int STAB_SHORT_CYCLES  = 256;
  localparam int STAB_LONG_CYCLES   = 4096;
  localparam int CNT_W              = 20;

endpackage

// ### hw/ext_line_sense.sv
// One external interrupt line: pin synchroniser, sensitivity decode, request latch
`timescale 1ns/1ps
module ext_line_sense
  import pwr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] sense_i,
  input  wire logic       clear_i,
  output logic            req_o
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic latch_q;
  wire  rise     = sync2_q & ~sync3_q;
  wire  fall     = ~sync2_q & sync3_q;
  wire  edge_hit = ((sense_i == SENSE_BOTH) & (rise | fall)) |
                   ((sense_i == SENSE_RISE) & rise) |
                   (((sense_i == SENSE_FALL) | (sense_i == SENSE_FALL_LOW)) & fall);
  // Level request follows the pin, never latched, so an ack cannot drop it
  wire  low_lvl  = (sense_i == SENSE_FALL_LOW) & ~sync2_q & ~sync3_q;

  // Idle high: pins are expected to sit pulled up
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      latch_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      latch_q <= edge_hit | (latch_q & ~clear_i);
    end
  end

  assign req_o = latch_q | low_lvl;

  a_ack_clears_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_i && !edge_hit |=> !latch_q) else $error("edge request not cleared by ack");
  a_level_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    low_lvl |-> req_o) else $error("low level request dropped");
  a_rise_latches: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (sense_i == SENSE_RISE) && rise |=> req_o) else $error("rising edge lost");

endmodule

// ### hw/power_mode_ctrl.sv
// Power mode controller with external interrupt pin selection and sensitivity
//
// What this block does
// - Sensitivity register holds four two-bit line fields
// - Codes: fall+low, rise, fall, both edges
// - Sensitivity writes only while interrupt mask set
// - Line 3 selects port B bits 0-2
// - Line 2 selects port B bits 3-6
// - Port B bit 4 never wakes from HALT
// - Line 1 selects port A 4-7, default 7
// - Line 0 selects port A 0-3, default 0
// - Reset always enters RUN at master clock
// - Slow mode divides oscillator clock by 32
// - WAIT during slow mode gives SLOW-WAIT
// - WAIT stops CPU, peripherals keep running
// - WAIT clears mask, exits on interrupt
// - Service sets mask, return restores saved mask
// - HALT only without active-halt or auto-wake
// - HALT exit waits 256 or 4096 cycles
// - Entering HALT forces interrupt mask clear
// - HALT stops oscillator and peripheral clocks
// - Watchdog option decides reset or HALT
// - PLL option adds start-up delay after stabilisation
// - Edge requests latch, clear on service entry
// - Interrupt taken in RUN when requested and unmasked
`timescale 1ns/1ps
module power_mode_ctrl
  import pwr_pkg::*;
#(
  parameter int unsigned PLL_START_TIME_NS = 1000000
)
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // Pins
  input  wire logic [7:0]  port_a_i,
  input  wire logic [6:0]  port_b_i,
  // CPU core side
  input  wire logic        wait_instr_i,
  input  wire logic        halt_instr_i,
  input  wire logic        irq_ack_i,
  input  wire logic [1:0]  irq_ack_line_i,
  input  wire logic        irq_return_i,
  input  wire logic        mask_set_i,
  input  wire logic        mask_clr_i,
  input  wire logic        other_irq_i,
  // Watchdog and option bits
  input  wire logic        watchdog_enabled_i,
  input  wire logic        watchdog_in_halt_option_i,
  input  wire logic        pll_enable_opt_i,
  // Outputs
  output logic             irq_take_o,
  output logic [1:0]       irq_line_o,
  output logic             irq_mask_o,
  output logic [3:0]       ext_irq_req_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             osc_on_o,
  output logic             watchdog_reset_o,
  output logic [2:0]       mode_o
);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PLL_START_CYCLES =
    (PLL_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mode_t              state_q;
  mode_t              state_d;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   cnt_d;
  logic [3:0]         div_q;
  logic               mask_q;
  logic               mask_d;
  logic               saved_mask_q;
  logic [7:0]         sense_q;
  logic [7:0]         pinsel_q;
  logic [7:0]         clkctrl_q;
  logic               cpu_en_q;
  logic               periph_en_q;
  logic               osc_on_q;
  logic               wdg_rst_q;
  logic [3:0]         ext_req;
  logic [3:0]         line_pin;
  logic [3:0]         line_clr;

  // ----------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------
  wire [1:0] sel3 = pinsel_q[LINE3_LSB+:2];
  wire [1:0] sel2 = pinsel_q[LINE2_LSB+:2];
  wire [1:0] sel1 = pinsel_q[LINE1_LSB+:2];
  wire [1:0] sel0 = pinsel_q[LINE0_LSB+:2];

  // Unused code 11 on line 3 reads as an idle high pin
  assign line_pin[3] = (sel3 == 2'h3) ? 1'b1 : port_b_i[sel3];
  assign line_pin[2] = port_b_i[3'(sel2) + 3'h3];
  assign line_pin[1] = port_a_i[3'(sel1) + 3'h4];
  assign line_pin[0] = port_a_i[3'(sel0)];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      assign line_clr[gi] = irq_ack_i && (irq_ack_line_i == 2'(gi));
      ext_line_sense u_sense (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (line_pin[gi]),
        .sense_i  (sense_q[2*gi+:2]),
        .clear_i  (line_clr[gi]),
        .req_o    (ext_req[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt request and wake decode
  // ----------------------------------------------------------------
  wire [3:0] wake_req    = ext_req & {1'b1, sel2 != LINE2_NOWAKE_SEL, 2'b11};
  wire       irq_pending = (|ext_req) && !mask_q;
  wire       wake_now    = (|wake_req) && !mask_q;
  wire       in_run      = (state_q == MODE_RUN);
  wire       halt_ok     = !clkctrl_q[CTL_ACTIVE_HALT_BIT] &&
                           !clkctrl_q[CTL_AUTO_WAKE_BIT];
  wire       wdg_kill    = watchdog_enabled_i && !watchdog_in_halt_option_i;
  wire       enter_wait  = in_run && wait_instr_i;
  wire       halt_cmd    = in_run && !wait_instr_i && halt_instr_i && halt_ok;
  wire       enter_halt  = halt_cmd && !wdg_kill;
  wire       slow_mode   = clkctrl_q[CTL_SLOW_BIT];
  wire       tick        = !slow_mode || (div_q == 4'h0);
  wire [CNT_W-1:0] stab_target = clkctrl_q[CTL_LONG_STAB_BIT] ?
                                 CNT_W'(STAB_LONG_CYCLES) : CNT_W'(STAB_SHORT_CYCLES);
  wire [CNT_W-1:0] pll_target  = CNT_W'(PLL_START_CYCLES);

  assign irq_take_o = in_run && irq_pending;
  assign irq_line_o = ext_req[0] ? 2'h0 : ext_req[1] ? 2'h1 : ext_req[2] ? 2'h2 : 2'h3;

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_W'(1);
    case (state_q)
      MODE_RUN: begin
        if (enter_wait) begin
          state_d = MODE_WAIT;
        end else if (enter_halt) begin
          state_d = MODE_HALT;
        end
      end
      MODE_WAIT: begin
        if (irq_pending || other_irq_i) begin
          state_d = MODE_RUN;
        end
      end
      MODE_HALT: begin
        cnt_d = '0;
        if (wake_now) begin
          state_d = MODE_STABILISE;
        end
      end
      MODE_STABILISE: begin
        if (cnt_q == stab_target - CNT_W'(1)) begin
          cnt_d   = '0;
          state_d = pll_enable_opt_i ? MODE_PLL_START : MODE_RUN;
        end
      end
      MODE_PLL_START: begin
        if (cnt_q == pll_target - CNT_W'(1)) begin
          state_d = MODE_RUN;
        end
      end
      default: begin
        state_d = MODE_RUN;
      end
    endcase
  end

  // Interrupt mask; CPU requests only count while it runs
  always_comb begin
    mask_d = mask_q;
    if (in_run && irq_ack_i) begin
      mask_d = 1'b1;
    end else if (in_run && irq_return_i) begin
      mask_d = saved_mask_q;
    end else if (enter_wait || enter_halt) begin
      mask_d = 1'b0;
    end else if (in_run && mask_set_i) begin
      mask_d = 1'b1;
    end else if (in_run && mask_clr_i) begin
      mask_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= MODE_RUN;
      cnt_q        <= '0;
      mask_q       <= 1'b1;
      saved_mask_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      mask_q  <= mask_d;
      if (in_run && irq_ack_i) begin
        saved_mask_q <= mask_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  // Slow divider keeps running in WAIT, which yields SLOW-WAIT
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q       <= 4'h0;
      cpu_en_q    <= 1'b0;
      periph_en_q <= 1'b0;
      osc_on_q    <= 1'b1;
      wdg_rst_q   <= 1'b0;
    end else begin
      // Parked at 1 so the first slow tick comes a full period after the last fast one
      div_q       <= !slow_mode ? 4'h1 :
                     (div_q == 4'(SLOW_TICK_CYCLES - 1)) ? 4'h0 : div_q + 4'h1;
      cpu_en_q    <= in_run && tick;
      periph_en_q <= (in_run || state_q == MODE_WAIT) && tick;
      osc_on_q    <= (state_q != MODE_HALT);
      wdg_rst_q   <= halt_cmd && wdg_kill;
    end
  end

  assign cpu_clk_en_o     = cpu_en_q;
  assign periph_clk_en_o  = periph_en_q;
  assign osc_on_o         = osc_on_q;
  assign watchdog_reset_o = wdg_rst_q;
  assign irq_mask_o       = mask_q;
  assign ext_irq_req_o    = ext_req;
  assign mode_o           = state_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign awready_o = !aw_held_q && !bvalid_q;
  assign wready_o  = !w_held_q && !bvalid_q;
  assign arready_o = !rvalid_q;

  wire [7:0] wr_word  = {awaddr_q[7:2], 2'b00};
  wire [7:0] rd_word  = {araddr_i[7:2], 2'b00};
  wire       wr_go    = aw_held_q && w_held_q;
  wire       wr_sense = wr_go && wlane_q && (wr_word == OFS_SENSE);
  wire       wr_psel  = wr_go && wlane_q && (wr_word == OFS_PINSEL);
  wire       wr_cctl  = wr_go && wlane_q && (wr_word == OFS_CLKCTRL);
  wire       wr_hit   = (wr_word == OFS_SENSE) || (wr_word == OFS_PINSEL) ||
                        (wr_word == OFS_CLKCTRL) || (wr_word == OFS_STATUS);
  wire       rd_hit   = (rd_word == OFS_SENSE) || (rd_word == OFS_PINSEL) ||
                        (rd_word == OFS_CLKCTRL) || (rd_word == OFS_STATUS);
  wire [31:0] status_word = {23'h0, slow_mode, ext_req, mask_q, state_q};
  wire [31:0] rd_mux  = (rd_word == OFS_SENSE)   ? {24'h0, sense_q}   :
                        (rd_word == OFS_PINSEL)  ? {24'h0, pinsel_q}  :
                        (rd_word == OFS_CLKCTRL) ? {24'h0, clkctrl_q} :
                        (rd_word == OFS_STATUS)  ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata_i[7:0];
        wlane_q  <= wstrb_i[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sense_q   <= SENSE_RESET;
      pinsel_q  <= PINSEL_RESET;
      clkctrl_q <= CLKCTRL_RESET;
    end else begin
      // Ignored while unmasked so a live line cannot see a false edge
      if (wr_sense && mask_q) begin
        sense_q <= wdata_q;
      end
      if (wr_psel) begin
        pinsel_q <= wdata_q;
      end
      if (wr_cctl) begin
        clkctrl_q <= {4'h0, wdata_q[3:0]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid_o = bvalid_q;
  assign bresp_o  = bresp_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o  = rdata_q;
  assign rresp_o  = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] chk_stab_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chk_stab_q <= '0;
    end else begin
      chk_stab_q <= (state_q == MODE_STABILISE) ? chk_stab_q + CNT_W'(1) : '0;
    end
  end

  a_sense_write_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_sense && !mask_q |=> $stable(sense_q)) else $error("sense written while unmasked");
  a_wait_cpu_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == MODE_WAIT |=> !cpu_clk_en_o) else $error("CPU clocked in WAIT");
  a_wait_entry_mask: assert property (@(posedge clk_i) disable iff (!resetn_i)
    enter_wait |=> state_q == MODE_WAIT && !mask_q) else $error("bad WAIT entry");
  a_halt_mask_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == MODE_HALT |-> !mask_q) else $error("mask set in HALT");
  a_halt_clocks_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == MODE_HALT |=> !osc_on_o && !periph_clk_en_o) else $error("clock on in HALT");
  a_stab_length: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(state_q == MODE_STABILISE) |-> chk_stab_q == stab_target)
    else $error("stabilisation length wrong");
  a_pll_after_stab: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == MODE_STABILISE && state_d != MODE_STABILISE && pll_enable_opt_i
    |=> state_q == MODE_PLL_START) else $error("PLL delay skipped");
  a_wdg_halt_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    halt_cmd && wdg_kill |=> watchdog_reset_o && state_q == MODE_RUN)
    else $error("watchdog halt reset missing");
  a_halt_blocked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    in_run && halt_instr_i && !halt_ok |=> state_q != MODE_HALT)
    else $error("HALT entered with auto-wake or active-halt");
  a_pb4_no_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == MODE_HALT && sel2 == LINE2_NOWAKE_SEL && ext_req == 4'h4
    |=> state_q == MODE_HALT) else $error("line 2 on PB4 woke HALT");
  a_take_unmasked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    irq_take_o |-> !mask_q && (|ext_req)) else $error("interrupt taken while masked");
  a_ack_sets_mask: assert property (@(posedge clk_i) disable iff (!resetn_i)
    in_run && irq_ack_i |=> mask_q) else $error("mask not set on service");
  a_slow_divide: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cpu_clk_en_o && slow_mode && in_run |=> !cpu_clk_en_o ##15
    (cpu_clk_en_o || !slow_mode || !in_run)) else $error("slow divide wrong");

endmodule

// ### verification/cpu_model.sv
// CPU core model: enters the service routine of a taken external request
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       en_i,
  input  wire logic       take_i,
  input  wire logic [1:0] line_i,
  output logic            ack_o,
  output logic [1:0]      ack_line_o
);
  // One ack per taken request, a cycle late as a real core would be
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o      <= 1'b0;
      ack_line_o <= 2'h0;
    end else begin
      ack_o      <= en_i && take_i && !ack_o;
      ack_line_o <= line_i;
    end
  end
endmodule

// ### verification/power_mode_ctrl_test.sv
// Testbench for the power mode and external wake controller
`timescale 1ns/1ps
module power_mode_ctrl_test
  import pwr_pkg::*;
;
  logic        clk_i = 0, resetn_i = 0;
  logic [7:0]  awaddr = 0, araddr = 0, pa = 8'hff;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [6:0]  pb = 7'h7f;
  logic [4:0]  ev = 0;
  logic        oth = 0, wd_en = 0, wd_opt = 0, ack_en = 0, pll = 0;
  localparam int PLL_NS = 2000;
  logic        awready, wready, bvalid, arready, rvalid, ack, take, mask, osc, wdr, cen, pen;
  logic [1:0]  bresp, rresp, ack_line, line;
  logic [3:0]  req;
  logic [2:0]  mode;
  int          mismatches = 0, num_checks = 0, cyc = 0, c1, c2;

  always #50 clk_i = ~clk_i;

  power_mode_ctrl #(.PLL_START_TIME_NS(PLL_NS)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .port_a_i(pa), .port_b_i(pb),
    .wait_instr_i(ev[0]), .halt_instr_i(ev[1]), .irq_ack_i(ack), .irq_ack_line_i(ack_line),
    .irq_return_i(ev[2]), .mask_set_i(ev[3]), .mask_clr_i(ev[4]), .other_irq_i(oth),
    .watchdog_enabled_i(wd_en), .watchdog_in_halt_option_i(wd_opt),
    .pll_enable_opt_i(pll), .irq_take_o(take), .irq_line_o(line), .irq_mask_o(mask),
    .ext_irq_req_o(req), .cpu_clk_en_o(cen), .periph_clk_en_o(pen), .osc_on_o(osc),
    .watchdog_reset_o(wdr), .mode_o(mode));

  cpu_model cpu (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(ack_en), .take_i(take),
    .line_i(line), .ack_o(ack), .ack_line_o(ack_line));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Handshakes judged at the falling edge, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_i);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = (bvalid === 1'b1);
      if (tb) chk(bresp, er, "bresp");
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic ta, tr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_i);
      ta = arvalid & arready;
      tr = (rvalid === 1'b1);
      if (tr) chk({rdata, rresp}, {24'h0, exp, er}, "read");
      @(posedge clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask

  task automatic cy(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic cnt(input int n);
    c1 = 0;
    c2 = 0;
    repeat (n) begin
      @(negedge clk_i);
      c1 += cen;
      c2 += pen;
    end
  endtask

  task automatic dwell(input logic [2:0] m, output int n);
    n = 0;
    while (mode === m && n < 5000) begin
      n++;
      @(negedge clk_i);
    end
  endtask

  // Hang guard: the tests need about 4700 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(OFS_SENSE, SENSE_RESET, RESP_OKAY);
    rd(OFS_PINSEL, PINSEL_RESET, RESP_OKAY);
    rd(8'h20, 8'h00, RESP_SLVERR);
    rd(OFS_STATUS, 8'h08, RESP_OKAY);
    cy(1);
    chk({mode, mask}, {MODE_RUN, 1'b1}, "reset mode");
    wr(OFS_SENSE, 8'h02, RESP_OKAY);
    pulse(4);
    wr(OFS_SENSE, 8'hff, RESP_OKAY);
    rd(OFS_SENSE, 8'h02, RESP_OKAY);
    ack_en <= 1'b1;
    pa[0] <= 1'b0;
    cy(12);
    chk({req[0], mask}, 2'b01, "serviced edge");
    pulse(2);
    cy(2);
    chk(mask, 1'b0, "mask restored");
    pulse(3);
    pulse(0);
    cy(2);
    chk({mode, mask}, {MODE_WAIT, 1'b0}, "wait entry");
    @(posedge clk_i);
    oth <= 1'b1;
    cy(3);
    chk(mode, MODE_RUN, "wait exit");
    @(posedge clk_i);
    oth <= 1'b0;
    wd_en <= 1'b1;
    pulse(1);
    cnt(0);
    repeat (4) begin
      @(negedge clk_i);
      c1 += wdr;
    end
    chk({c1[3:0], mode}, {4'h1, MODE_RUN}, "watchdog");
    @(posedge clk_i);
    wd_opt <= 1'b1;
    pa[0] <= 1'b1;
    pulse(3);
    wr(OFS_PINSEL, 8'h1c, RESP_OKAY);
    pulse(1);
    cy(2);
    chk({mode, mask, osc}, {MODE_HALT, 2'b00}, "halt entry");
    @(posedge clk_i);
    pb[4] <= 1'b0;
    cy(12);
    chk(mode, MODE_HALT, "no wake");
    @(posedge clk_i);
    pa[0] <= 1'b0;
    c1 = 0;
    repeat (12) begin
      @(negedge clk_i);
      if (mode !== MODE_HALT) break;
    end
    while (mode === MODE_STABILISE && c1 < 5000) begin
      c1++;
      @(negedge clk_i);
    end
    chk({c1, mode}, {STAB_SHORT_CYCLES, MODE_RUN}, "stabilise");
    cy(12);
    chk(req[2], 1'b1, "low level");
    pulse(2);
    cy(12);
    chk({req[2], mask}, 2'b11, "level after ack");
    @(posedge clk_i);
    pb[4] <= 1'b1;
    wr(OFS_SENSE, 8'h42, RESP_OKAY);
    @(posedge clk_i);
    pb[0] <= 1'b0;
    cy(6);
    chk(req[3], 1'b0, "fall ignored");
    @(posedge clk_i);
    pb[0] <= 1'b1;
    cy(6);
    chk(req[3], 1'b1, "rise latched");
    pulse(4);
    cy(6);
    chk({req[3], mask}, 2'b01, "rise serviced");
    wr(OFS_CLKCTRL, 8'h01, RESP_OKAY);
    cy(4);
    cnt(64);
    chk(c1, 64 / SLOW_TICK_CYCLES, "slow rate");
    pulse(0);
    cy(40);
    cnt(64);
    chk({mode, c1[7:0], c2[7:0]}, {MODE_WAIT, 8'h00, 8'h04}, "slow wait");
    @(posedge clk_i);
    oth <= 1'b1;
    pa[0] <= 1'b1;
    pll <= 1'b1;
    cy(3);
    chk(mode, MODE_RUN, "slow wait exit");
    @(posedge clk_i);
    oth <= 1'b0;
    wr(OFS_CLKCTRL, 8'h02, RESP_OKAY);
    pulse(1);
    cy(2);
    chk(mode, MODE_RUN, "halt blocked");
    wr(OFS_CLKCTRL, 8'h08, RESP_OKAY);
    pulse(1);
    @(posedge clk_i);
    pa[0] <= 1'b0;
    dwell(MODE_HALT, c1);
    dwell(MODE_STABILISE, c1);
    dwell(MODE_PLL_START, c2);
    chk({c1, c2}, {STAB_LONG_CYCLES, PLL_NS / CLK_PERIOD_NS}, "long wake");
    chk(mode, MODE_RUN, "pll exit");
    close_out();
  end
endmodule
